// ==== rtl/dsm_pkg.sv ====
/*
  Constants, command codes, status codes and states for the drive state machine.
  Assumes one synchronous clock domain shared by both ends.
*/
package dsm_pkg;
  localparam logic [15:0] DSM_REG_COMMAND      = 16'h6040;
  localparam logic [15:0] DSM_REG_STATUS       = 16'h6041;
  localparam logic [15:0] DSM_REG_MODE         = 16'h6060;
  localparam logic [15:0] DSM_REG_QS_OPTION    = 16'h605A;
  localparam logic [15:0] DSM_REG_HALT_OPTION  = 16'h605D;
  localparam logic [15:0] DSM_CMD_RESET_VAL    = 16'h0000;
  localparam logic [15:0] DSM_CMD_SHUTDOWN     = 16'h0006;
  localparam logic [15:0] DSM_CMD_SWITCH_ON    = 16'h0007;
  localparam logic [15:0] DSM_CMD_ENABLE_OP    = 16'h000F;
  localparam logic [15:0] DSM_CMD_DISABLE_V    = 16'h0000;
  localparam logic [15:0] DSM_CMD_QUICK_STOP   = 16'h0002;
  localparam logic [15:0] DSM_CMD_FAULT_RESET  = 16'h0080;
  localparam logic [15:0] DSM_ST_NOT_READY     = 16'h0000;
  localparam logic [15:0] DSM_ST_SW_DISABLED   = 16'h0270;
  localparam logic [15:0] DSM_ST_READY         = 16'h0231;
  localparam logic [15:0] DSM_ST_SWITCHED_ON   = 16'h0233;
  localparam logic [15:0] DSM_ST_OP_ENABLED    = 16'h0237;
  localparam logic [15:0] DSM_ST_QUICK_STOP    = 16'h0217;
  localparam logic [15:0] DSM_ST_FAULT_REACT   = 16'h02B6;
  localparam logic [15:0] DSM_ST_FAULT         = 16'h0238;
  localparam int          DSM_BIT_SWITCH_ON    = 0;
  localparam int          DSM_BIT_EN_VOLTAGE   = 1;
  localparam int          DSM_BIT_QUICK_STOP_N = 2;
  localparam int          DSM_BIT_EN_OP        = 3;
  localparam int          DSM_BIT_HOME_START   = 4;
  localparam int          DSM_BIT_FAULT_RESET  = 7;
  localparam int          DSM_BIT_HALT         = 8;
  localparam int          DSM_SBIT_TARGET      = 10;
  localparam logic [7:0]  DSM_MODE_HOMING      = 8'h06;
  localparam logic [7:0]  DSM_MODE_RESET_VAL   = 8'h08;
  localparam logic [15:0] DSM_QS_OPT_RESET_VAL = 16'h0002;
  localparam logic [15:0] DSM_HALT_RESET_VAL   = 16'h0001;
  localparam logic [15:0] DSM_QS_OPT_AUTO_MAX  = 16'h0003;
  localparam logic [15:0] DSM_LOW_STATUS_MASK  = 16'h03FF;
  localparam int          DSM_INIT_CYCLES      = 16;
  localparam int          DSM_REACT_CYCLES     = 8;

  typedef enum {
    DSM_S_NOT_READY,
    DSM_S_SW_DISABLED,
    DSM_S_READY,
    DSM_S_SWITCHED_ON,
    DSM_S_OP_ENABLED,
    DSM_S_QUICK_STOP,
    DSM_S_FAULT_REACT,
    DSM_S_FAULT
  } dsm_state_t;

  typedef enum {
    DSM_C_NONE,
    DSM_C_SHUTDOWN,
    DSM_C_SWITCH_ON,
    DSM_C_SWITCH_ON_EN,
    DSM_C_DISABLE_V,
    DSM_C_QUICK_STOP
  } dsm_cmd_t;
endpackage

// ==== rtl/dsm_link_if.sv ====
/*
  Object access link between fieldbus master end and drive end.
  Assumes both ends run on the same sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface dsm_link_if;
  logic [15:0] obj_index;
  logic [15:0] obj_wdata;
  logic        obj_write;
  logic [15:0] status_word;
  logic [7:0]  mode_display;

  modport master (output obj_index, output obj_wdata, output obj_write,
                  input status_word, input mode_display);
  modport drive  (input obj_index, input obj_wdata, input obj_write,
                  output status_word, output mode_display);
endinterface
`default_nettype wire

// ==== rtl/dsm_master.sv ====
/*
  Fieldbus master end: software writes objects through a plain register port,
  the end forwards them to the drive and reads back status.
  Assumes the drive end on the same clock; read data one cycle after read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_master
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Software port
  input  wire logic [15:0] sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_write,
  input  wire logic        sw_read,
  output logic      [15:0] sw_rdata,
  // Link
  dsm_link_if.master       link
);
  logic [15:0] idx;
  logic [15:0] wdat;
  logic        wr;
  logic [15:0] next_idx;
  logic [15:0] next_wdat;
  logic        next_wr;
  logic [15:0] last_cmd;
  logic [15:0] next_last_cmd;
  logic [15:0] next_rdata;

  always_comb begin
    next_idx      = idx;
    next_wdat     = wdat;
    next_wr       = 1'b0;
    next_last_cmd = last_cmd;
    next_rdata    = 16'h0000;
    if (sw_write) begin
      // Command codes travel unchanged to the drive
      next_idx  = sw_addr;
      next_wdat = sw_wdata;
      next_wr   = 1'b1;
      if (sw_addr == DSM_REG_COMMAND) begin
        next_last_cmd = sw_wdata;
      end
    end
    if (sw_read) begin
      unique case (sw_addr)
        DSM_REG_STATUS:  next_rdata = link.status_word;
        DSM_REG_COMMAND: next_rdata = last_cmd;
        DSM_REG_MODE:    next_rdata = {8'h00, link.mode_display};
        default:         next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idx      <= 16'h0000;
      wdat     <= 16'h0000;
      wr       <= 1'b0;
      last_cmd <= DSM_CMD_RESET_VAL;
      sw_rdata <= 16'h0000;
    end else begin
      idx      <= next_idx;
      wdat     <= next_wdat;
      wr       <= next_wr;
      last_cmd <= next_last_cmd;
      sw_rdata <= next_rdata;
    end
  end

  assign link.obj_index = idx;
  assign link.obj_wdata = wdat;
  assign link.obj_write = wr;
endmodule
`default_nettype wire

// ==== rtl/dsm_drive.sv ====
/*
  Drive end: object store, command decode and the drive-profile state machine.
  Assumes the master end on the same clock writes objects one cycle at a time.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dsm_drive
  import dsm_pkg::*;
#(
  parameter int INIT_CYCLES  = DSM_INIT_CYCLES,
  parameter int REACT_CYCLES = DSM_REACT_CYCLES
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Link
  dsm_link_if.drive        link,
  // Drive conditions
  input  wire logic        init_error,
  input  wire logic        drive_failure,
  input  wire logic        stop_done,
  input  wire logic        target_reached,
  input  wire logic        limit_active,
  // Drive controls
  output logic             main_power_en,
  output logic             torque_en,
  output logic             homing_start,
  output logic             halt_req,
  output logic      [15:0] halt_option,
  output logic             fault_clear,
  output logic      [15:0] mode_bits
);
  // Counters are 16 bits wide and must load a nonzero count
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535 || REACT_CYCLES < 1 || REACT_CYCLES > 65535) begin : g_bad_counts
    $error("dsm_drive: cycle counts out of range");
  end

  function automatic dsm_cmd_t decode(input logic [15:0] w);
    // Only bits 0-3 are looked at here; bit7 is handled by the caller
    dsm_cmd_t c;
    c = DSM_C_NONE;
    if (!w[DSM_BIT_EN_VOLTAGE]) begin
      c = DSM_C_DISABLE_V;
    end else if (!w[DSM_BIT_QUICK_STOP_N]) begin
      c = DSM_C_QUICK_STOP;
    end else if (!w[DSM_BIT_SWITCH_ON]) begin
      c = DSM_C_SHUTDOWN;
    end else if (!w[DSM_BIT_EN_OP]) begin
      c = DSM_C_SWITCH_ON;
    end else begin
      c = DSM_C_SWITCH_ON_EN;
    end
    return c;
  endfunction

  dsm_state_t  state;
  dsm_state_t  next_state;
  logic [15:0] command;
  logic [15:0] next_command;
  logic [7:0]  mode;
  logic [7:0]  next_mode;
  logic [15:0] qs_option;
  logic [15:0] next_qs_option;
  logic [15:0] next_halt_option;
  logic        prev_reset_bit;
  logic        next_prev_reset_bit;
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_fault_clear;
  logic [15:0] status;
  logic [15:0] next_status;
  logic        next_main_power_en;
  logic        next_torque_en;
  logic        next_homing_start;
  logic        next_halt_req;
  logic [15:0] next_mode_bits;
  logic        reset_edge;
  logic        reset_held;
  dsm_cmd_t    cmd;

  always_comb begin
    next_command     = command;
    next_mode        = mode;
    next_qs_option   = qs_option;
    next_halt_option = halt_option;
    // Parameter writes accepted in every state
    if (link.obj_write) begin
      unique case (link.obj_index)
        DSM_REG_COMMAND:     next_command     = link.obj_wdata;
        DSM_REG_MODE:        next_mode        = link.obj_wdata[7:0];
        DSM_REG_QS_OPTION:   next_qs_option   = link.obj_wdata;
        DSM_REG_HALT_OPTION: next_halt_option = link.obj_wdata;
        default:             next_command     = command;
      endcase
    end
  end

  always_comb begin
    reset_edge          = command[DSM_BIT_FAULT_RESET] && !prev_reset_bit;
    reset_held          = command[DSM_BIT_FAULT_RESET];
    cmd                 = reset_held ? DSM_C_NONE : decode(command);
    next_prev_reset_bit = command[DSM_BIT_FAULT_RESET];
    next_state          = state;
    next_count          = count;
    next_fault_clear    = 1'b0;
    if (count != 16'h0000) begin
      next_count = 16'(count - 16'h0001);
    end
    unique case (state)
      DSM_S_NOT_READY: begin
        if (init_error) begin
          next_state = DSM_S_FAULT_REACT;
          next_count = 16'(REACT_CYCLES);
        end else if (count == 16'h0000) begin
          next_state = DSM_S_SW_DISABLED;
        end
      end
      DSM_S_SW_DISABLED: begin
        if (cmd == DSM_C_SHUTDOWN) begin
          next_state = DSM_S_READY;
        end
      end
      DSM_S_READY: begin
        unique case (cmd)
          DSM_C_DISABLE_V, DSM_C_QUICK_STOP: next_state = DSM_S_SW_DISABLED;
          DSM_C_SWITCH_ON, DSM_C_SWITCH_ON_EN: next_state = DSM_S_SWITCHED_ON;
          default: next_state = state;
        endcase
      end
      DSM_S_SWITCHED_ON: begin
        unique case (cmd)
          DSM_C_DISABLE_V, DSM_C_QUICK_STOP: next_state = DSM_S_SW_DISABLED;
          DSM_C_SHUTDOWN:     next_state = DSM_S_READY;
          DSM_C_SWITCH_ON_EN: next_state = DSM_S_OP_ENABLED;
          default:            next_state = state;
        endcase
      end
      DSM_S_OP_ENABLED: begin
        unique case (cmd)
          DSM_C_DISABLE_V:  next_state = DSM_S_SW_DISABLED;
          DSM_C_QUICK_STOP: next_state = DSM_S_QUICK_STOP;
          DSM_C_SHUTDOWN:   next_state = DSM_S_READY;
          DSM_C_SWITCH_ON:  next_state = DSM_S_SWITCHED_ON;
          default:          next_state = state;
        endcase
      end
      DSM_S_QUICK_STOP: begin
        if (cmd == DSM_C_DISABLE_V) begin
          next_state = DSM_S_SW_DISABLED;
        end else if (stop_done && qs_option <= DSM_QS_OPT_AUTO_MAX) begin
          next_state = DSM_S_SW_DISABLED;
        end
      end
      DSM_S_FAULT_REACT: begin
        if (count == 16'h0000) begin
          next_state = DSM_S_FAULT;
        end
      end
      DSM_S_FAULT: begin
        if (reset_edge) begin
          next_state       = DSM_S_SW_DISABLED;
          next_fault_clear = 1'b1;
        end
      end
    endcase
    if (drive_failure && state != DSM_S_FAULT && state != DSM_S_FAULT_REACT) begin
      next_state = DSM_S_FAULT_REACT;
      next_count = 16'(REACT_CYCLES);
    end
  end

  always_comb begin
    unique case (next_state)
      DSM_S_NOT_READY:   next_status = DSM_ST_NOT_READY;
      DSM_S_SW_DISABLED: next_status = DSM_ST_SW_DISABLED;
      DSM_S_READY:       next_status = DSM_ST_READY;
      DSM_S_SWITCHED_ON: next_status = DSM_ST_SWITCHED_ON;
      DSM_S_OP_ENABLED:  next_status = DSM_ST_OP_ENABLED;
      DSM_S_QUICK_STOP:  next_status = DSM_ST_QUICK_STOP;
      DSM_S_FAULT_REACT: next_status = DSM_ST_FAULT_REACT;
      DSM_S_FAULT:       next_status = DSM_ST_FAULT;
    endcase
    next_status = next_status & DSM_LOW_STATUS_MASK;
    next_status[DSM_SBIT_TARGET]     = target_reached;
    next_status[DSM_SBIT_TARGET + 1] = limit_active;
    next_main_power_en = next_state inside {DSM_S_READY, DSM_S_SWITCHED_ON,
                                            DSM_S_OP_ENABLED, DSM_S_QUICK_STOP};
    next_torque_en     = (next_state == DSM_S_OP_ENABLED) && !drive_failure;
    next_homing_start  = (mode == DSM_MODE_HOMING) && command[DSM_BIT_HOME_START]
                         && (state == DSM_S_OP_ENABLED);
    next_halt_req      = command[DSM_BIT_HALT];
    next_mode_bits     = command & 16'h0270;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state          <= DSM_S_NOT_READY;
      command        <= DSM_CMD_RESET_VAL;
      mode           <= DSM_MODE_RESET_VAL;
      qs_option      <= DSM_QS_OPT_RESET_VAL;
      halt_option    <= DSM_HALT_RESET_VAL;
      prev_reset_bit <= 1'b0;
      count          <= 16'(INIT_CYCLES);
      fault_clear    <= 1'b0;
      status         <= DSM_ST_NOT_READY;
      main_power_en  <= 1'b0;
      torque_en      <= 1'b0;
      homing_start   <= 1'b0;
      halt_req       <= 1'b0;
      mode_bits      <= 16'h0000;
    end else begin
      state          <= next_state;
      command        <= next_command;
      mode           <= next_mode;
      qs_option      <= next_qs_option;
      halt_option    <= next_halt_option;
      prev_reset_bit <= next_prev_reset_bit;
      count          <= next_count;
      fault_clear    <= next_fault_clear;
      status         <= next_status;
      main_power_en  <= next_main_power_en;
      torque_en      <= next_torque_en;
      homing_start   <= next_homing_start;
      halt_req       <= next_halt_req;
      mode_bits      <= next_mode_bits;
    end
  end

  assign link.status_word  = status;
  assign link.mode_display = mode;
endmodule
`default_nettype wire

// ==== verification/dsm_properties.sv ====
/*
  Link properties of the master and drive ends of the drive state machine.
  Assumes one sys_clk and a synchronous active-high reset shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_properties (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // Link
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic        obj_write,
  input wire logic [15:0] status_word,
  input wire logic [7:0]  mode_display
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire       wc = obj_write && obj_index == 16'h6040;
  wire       cw = wc && !obj_wdata[7];
  wire [9:0] st = status_word[9:0];
  logic       last_fr;
  logic       next_last_fr;
  logic [7:0] last_mode;
  logic [7:0] next_last_mode;
  // Last fault reset bit and last mode written
  always_comb begin
    next_last_fr   = wc ? obj_wdata[7] : last_fr;
    next_last_mode = (obj_write && obj_index == 16'h6060) ? obj_wdata[7:0] : last_mode;
  end
  always_ff @(posedge sys_clk) begin
    last_fr   <= reset ? 1'b0 : next_last_fr;
    last_mode <= reset ? 8'h08 : next_last_mode;
  end
  property p_init; $fell(reset) |-> (status_word == 16'h0000) [*4]; endproperty
  a_init: assert property (p_init) else $error("status not zero after reset");
  property p_leave; $past(st) == 10'h000 && st != 10'h000 |-> st inside {10'h270, 10'h2B6}; endproperty
  a_leave: assert property (p_leave) else $error("bad exit from not ready");
  property p_shut; cw && obj_wdata[2:0] == 3'h6 && st inside {10'h270, 10'h233, 10'h237} |-> ##[1:4] st == 10'h231;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown missed ready");
  property p_swon; cw && obj_wdata[3:0] == 4'h7 && st inside {10'h231, 10'h237} |-> ##[1:4] st == 10'h233; endproperty
  a_swon: assert property (p_swon) else $error("switch on missed");
  property p_enop; cw && obj_wdata[3:0] == 4'hF && st == 10'h233 |-> ##[1:4] st == 10'h237; endproperty
  a_enop: assert property (p_enop) else $error("enable missed");
  property p_full; cw && obj_wdata[3:0] == 4'hF && st == 10'h231 |-> ##[1:4] st == 10'h233 ##1 st == 10'h237;
  endproperty
  a_full: assert property (p_full) else $error("full enable path wrong");
  property p_dis; cw && !obj_wdata[1] && st inside {10'h231, 10'h233, 10'h237, 10'h217} |-> ##[1:4] st == 10'h270;
  endproperty
  a_dis: assert property (p_dis) else $error("disable voltage missed");
  property p_qs; cw && obj_wdata[2:1] == 2'b01 && st == 10'h237 |-> ##[1:4] st == 10'h217; endproperty
  a_qs: assert property (p_qs) else $error("quick stop missed");
  property p_qsx; st == 10'h217 ##1 st != 10'h217 |-> st inside {10'h270, 10'h2B6}; endproperty
  a_qsx: assert property (p_qsx) else $error("bad exit from quick stop");
  property p_react; $rose(st == 10'h2B6) |-> (st == 10'h2B6) [*3] ##[1:20] st == 10'h238; endproperty
  a_react: assert property (p_react) else $error("fault reaction did not end in fault");
  property p_frst; wc && obj_wdata[7] && !last_fr && st == 10'h238 |-> ##[1:4] st == 10'h270; endproperty
  a_frst: assert property (p_frst) else $error("fault reset missed");
  property p_hold; wc && obj_wdata[7] && st == 10'h270 |-> (st == 10'h270) [*6]; endproperty
  a_hold: assert property (p_hold) else $error("command obeyed while reset bit high");
  property p_bad; cw && obj_wdata[3:0] == 4'h7 && st == 10'h270 |-> (st == 10'h270) [*5]; endproperty
  a_bad: assert property (p_bad) else $error("illegal command changed state");
  property p_high; status_word[15:12] == 4'h0; endproperty
  a_high: assert property (p_high) else $error("status high bits set");
  property p_mode; obj_write && obj_index == 16'h6060 |-> ##[1:3] mode_display == last_mode; endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");
  c_full: cover property (st == 10'h233 ##1 st == 10'h237);
  c_fault: cover property (st == 10'h2B6 ##1 st == 10'h238);
  c_qs: cover property (st == 10'h217 ##1 st == 10'h270);
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/*
  Self-checking bench: master and drive ends joined by the link, software port driven by tasks.
  Assumes the package and link interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsm_pkg::*;
  localparam int          INIT      = 6;
  localparam int          REACT     = 4;
  localparam logic [15:0] WORDS [16] = '{16'h0006, 16'h0007, 16'h0006, 16'h000F, 16'h0007, 16'h000F, 16'h0006,
    16'h0002, 16'h0006, 16'h0007, 16'h0002, 16'h0006, 16'h0000, 16'h0006, 16'h000F, 16'h0000};
  localparam logic [15:0] CODES [16] = '{16'h0231, 16'h0233, 16'h0231, 16'h0237, 16'h0233, 16'h0237, 16'h0231,
    16'h0270, 16'h0231, 16'h0233, 16'h0270, 16'h0231, 16'h0270, 16'h0231, 16'h0237, 16'h0270};
  logic        sys_clk, reset, sw_write, sw_read;
  logic        rd_pend = 1'b0;
  logic [15:0] sw_addr, sw_wdata, sw_rdata, halt_option, mode_bits;
  logic        init_error, drive_failure, stop_done, target_reached, limit_active;
  logic        main_power_en, torque_en, homing_start, halt_req, fault_clear;
  logic [15:0] exp_q[$];
  int          fails = 0;
  int          num_checks = 0;
  int          clears = 0;
  int          clears_base = 0;

  dsm_link_if dsm_link_if_i ();
  dsm_master dsm_master_i (.sys_clk(sys_clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .link(dsm_link_if_i));
  dsm_drive #(.INIT_CYCLES(INIT), .REACT_CYCLES(REACT)) dsm_drive_i (.sys_clk(sys_clk), .reset(reset),
    .link(dsm_link_if_i), .init_error(init_error), .drive_failure(drive_failure), .stop_done(stop_done),
    .target_reached(target_reached), .limit_active(limit_active), .main_power_en(main_power_en),
    .torque_en(torque_en), .homing_start(homing_start), .halt_req(halt_req), .halt_option(halt_option),
    .fault_clear(fault_clear), .mode_bits(mode_bits));
  dsm_properties dsm_properties_i (.sys_clk(sys_clk), .reset(reset), .obj_index(dsm_link_if_i.obj_index),
    .obj_wdata(dsm_link_if_i.obj_wdata), .obj_write(dsm_link_if_i.obj_write),
    .status_word(dsm_link_if_i.status_word), .mode_display(dsm_link_if_i.mode_display));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Status code with the target and limit bits folded in
  function automatic logic [15:0] st(input logic [15:0] code);
    return code | {4'h0, limit_active, target_reached, 10'h000};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge sys_clk);
    sw_write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge sys_clk);
    sw_read <= 1'b0;
  endtask

  // Command word with random reserved bits, then status read back
  task automatic cmd(input logic [15:0] w, input logic [15:0] code);
    target_reached <= 1'($urandom);
    limit_active   <= 1'($urandom);
    wr(16'h6040, w | (16'($urandom) & 16'hFC00));
    repeat (4) @(posedge sys_clk);
    rd(16'h6041, st(code));
  endtask

  task automatic do_reset();
    reset          <= 1'b1;
    target_reached <= 1'b0;
    limit_active   <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  // Read results are compared against the oldest note
  always @(posedge sys_clk) begin
    rd_pend <= sw_read;
    if (rd_pend === 1'b1) begin
      check(sw_rdata, exp_q.pop_front());
    end
    if (fault_clear === 1'b1) begin
      clears++;
    end
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(32'h6385));
    reset          = 1'b1;
    sw_addr        = 16'h0000;
    sw_wdata       = 16'h0000;
    sw_write       = 1'b0;
    sw_read        = 1'b0;
    init_error     = 1'b0;
    drive_failure  = 1'b0;
    stop_done      = 1'b0;
    target_reached = 1'b0;
    limit_active   = 1'b0;
    do_reset();
    rd(16'h6041, 16'h0000);
    rd(16'h6060, 16'h0008);
    rd(16'h1234, 16'h0000);
    rd(16'h6040, 16'h0000);
    repeat (INIT + 2) @(posedge sys_clk);
    rd(16'h6041, 16'h0270);
    check(16'(main_power_en), 16'h0000);
    cmd(16'h0007, 16'h0270);
    cmd(16'h0086, 16'h0270);
    for (int i = 0; i < 16; i++) begin
      cmd(WORDS[i], CODES[i]);
    end
    cmd(16'h0006, 16'h0231);
    check(16'(main_power_en), 16'h0001);
    check(16'(torque_en), 16'h0000);
    wr(16'h6060, 16'h0006);
    cmd(16'h011F, 16'h0237);
    check(16'(torque_en), 16'h0001);
    check(16'(homing_start), 16'h0001);
    check(16'(halt_req), 16'h0001);
    check(mode_bits, 16'h0010);
    rd(16'h6060, 16'h0006);
    wr(16'h6060, 16'h0008);
    cmd(16'h000F, 16'h0237);
    check(16'(homing_start), 16'h0000);
    cmd(16'h0002, 16'h0217);
    stop_done <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(16'h6041, st(16'h0270));
    stop_done <= 1'b0;
    cmd(16'h0006, 16'h0231);
    cmd(16'h000F, 16'h0237);
    wr(16'h605A, 16'h0005);
    cmd(16'h0002, 16'h0217);
    stop_done <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(16'h6041, st(16'h0217));
    stop_done <= 1'b0;
    cmd(16'h0000, 16'h0270);
    cmd(16'h0006, 16'h0231);
    cmd(16'h000F, 16'h0237);
    @(posedge sys_clk);
    drive_failure <= 1'b1;
    @(posedge sys_clk);
    drive_failure <= 1'b0;
    #1;
    check(16'(torque_en), 16'h0000);
    rd(16'h6041, st(16'h02B6));
    repeat (REACT + 2) @(posedge sys_clk);
    rd(16'h6041, st(16'h0238));
    wr(16'h605D, 16'h0003);
    repeat (3) @(posedge sys_clk);
    check(halt_option, 16'h0003);
    cmd(16'h0006, 16'h0238);
    clears_base = clears;
    cmd(16'h0080, 16'h0270);
    check(16'(clears - clears_base), 16'h0001);
    do_reset();
    repeat (4) @(posedge sys_clk);
    init_error <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(16'h6041, 16'h02B6);
    init_error <= 1'b0;
    repeat (REACT + 2) @(posedge sys_clk);
    rd(16'h6041, 16'h0238);
    repeat (3) @(posedge sys_clk);
    summarize();
  end
endmodule
`default_nettype wire
